// [common/fsw_defs.svh]
// Constants for the flash sector-info and no-erase write command block.
// Included by the package and the design; definitions only.
`ifndef FSW_DEFS_SVH
`define FSW_DEFS_SVH

// Register word offsets (byte addresses, one 32-bit word each)
`define FSW_OFS_DATA   6'h00
`define FSW_OFS_ERR    6'h04
`define FSW_OFS_COUNT  6'h08
`define FSW_OFS_SECT   6'h0C
`define FSW_OFS_CYLLO  6'h10
`define FSW_OFS_CYLHI  6'h14
`define FSW_OFS_DEVHD  6'h18
`define FSW_OFS_STAT   6'h1C
`define FSW_OFS_MULT   6'h20

// Opcodes
`define FSW_OP_INFO    8'h87
`define FSW_OP_WRMULT  8'hCD

// Status bits
`define FSW_ST_BSY     7
`define FSW_ST_DRIVE_READY_FLAG    6
`define FSW_ST_DF      5
`define FSW_ST_DRQ     3
`define FSW_ST_ERR     0

// Error bits
`define FSW_ER_ADDRESS_NOT_FOUND_BIT    4
`define FSW_ER_ABORTED_COMMAND_BIT    2
`define FSW_ER_MED     0

// Device/head fields
`define FSW_DH_LBA     6

// Record layout
`define FSW_REC_ERASED 8'h13
`define FSW_REC_WC_HI  8'h18
`define FSW_REC_WC_MD  8'h19
`define FSW_REC_WC_LO  8'h1A
`define FSW_BYTE_ONES  8'hFF
`define FSW_WORDS_SECT 8'hFF
`define FSW_MAX_LBA    28'hFFFFFFF

`endif

// [common/fsw_pkg.sv]
// Types shared by the command block and its bench.
// Assumes fsw_defs.svh is on the include path.
package fsw_pkg;
  `include "fsw_defs.svh"

  typedef enum logic [1:0] {
    FSW_IDLE,
    FSW_INFO,
    FSW_WRITE
  } fsw_state_t;

  // Media-side facts about the addressed sector
  typedef struct packed {
    logic        erased;
    logic [23:0] wcount;
  } fsw_sect_info_t;

  // One data word handed to the flash array
  typedef struct packed {
    logic [27:0] addr;
    logic [7:0]  word_idx;
    logic [15:0] data;
  } fsw_media_wr_t;
endpackage : fsw_pkg

// [hw/fsw_cmd.sv]
// Task-file command block: sector information read and no-erase
// multiple write, reached over a classic Wishbone slave.
// Assumes the flash array answers sector info and takes write words
// at once; media_err is valid at the last word of each sector.
//
// Notes on behaviour
// - Opcode 87h runs sector info, data in
// - Info command returns exactly 512 bytes
// - Bytes 0-6 hold CHS then LBA
// - Byte 13h is FFh erased, else 00h
// - Bytes 18h-1Ah write count, MSB first
// - Unsupported record fields may read zero
// - Good end: busy off, ready on, no error
// - Unsupported command sets the aborted bit
// - Error end reports error, busy off, ready
// - Error flag follows any error bit
// - Opcode CDh runs no-erase write, data out
// - Count 00h means 256 sectors
// - Start address from sector, cylinder registers
// - Device/head bit 6 picks LBA mode
// - Failure stops write, loads failing address
// - Missing address or geometry sets not-found
// - Out of range: not-found, never both
// - Media error sets media-error bit
// - Error end of write drops data request
// - One interrupt per block, not sector
// - Sectors written without implied erase
`timescale 1ns/1ps
`default_nettype none
`include "fsw_defs.svh"
module fsw_cmd
  import fsw_pkg::*;
(
  input  wire logic           core_clk,    // 250 MHz
  input  wire logic           rst_b,       // async reset
  input  wire logic           wb_cyc_i,    // bus cycle
  input  wire logic           wb_stb_i,    // strobe
  input  wire logic           wb_we_i,     // write
  input  wire logic [5:0]     wb_adr_i,    // byte address
  input  wire logic [3:0]     wb_sel_i,    // byte lanes
  input  wire logic [31:0]    wb_dat_i,    // write data
  output logic      [31:0]    wb_dat_o,    // read data
  output logic                wb_ack_o,    // ack
  input  wire fsw_sect_info_t sect_info,   // addressed sector
  input  wire logic           geom_valid,  // CHS translation ok
  input  wire logic [7:0]     geom_spt,    // sectors per track
  input  wire logic [3:0]     geom_heads,  // heads minus one
  input  wire logic [27:0]    max_lba,     // last user sector
  input  wire logic           media_err,   // sector write failed
  input  wire logic           dev_fault,   // fault seen
  output fsw_media_wr_t       media_wr,    // write word
  output logic                media_wr_vld,// write strobe
  output logic                host_irq     // to host, level
);

  // ----------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------
  logic       acc;
  logic       wr_acc;
  logic       rd_acc;
  logic       lane0;
  logic       lane1;
  fsw_state_t state;
  logic [7:0] err_reg;
  logic [7:0] count;
  logic [7:0] sect;
  logic [7:0] cyl_lo;
  logic [7:0] cyl_hi;
  logic [7:0] dev_hd;
  logic       busy_flag;
  logic       data_request_flag;
  logic       df;
  logic [7:0] mult;
  logic [7:0] word_idx;
  logic [8:0] left;
  logic [7:0] blk_left;
  logic       busy_cmd;

  assign acc    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_acc = acc && wb_we_i;
  assign rd_acc = acc && !wb_we_i;
  assign lane0  = wb_sel_i[0];
  assign lane1  = wb_sel_i[1];

  function automatic logic hit(input logic [5:0] ofs);
    hit = wb_adr_i == ofs;
  endfunction : hit

  // Single-cycle answer; the slave never asks for waits
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  // ----------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------
  logic        lba_mode;
  logic [27:0] cur_lba;
  logic [27:0] next_lba;
  logic        addr_bad;

  assign lba_mode = dev_hd[`FSW_DH_LBA];
  assign cur_lba  = {dev_hd[3:0], cyl_hi, cyl_lo, sect};
  assign next_lba = cur_lba + 28'h0000001;

  // CHS flattened to a linear index for the range check
  function automatic logic [27:0] chs_lin();
    logic [27:0] trk;
    trk = ({12'h000, cyl_hi, cyl_lo} * {23'h000000, {1'b0, geom_heads} + 5'h01})
          + {24'h000000, dev_hd[3:0]};
    chs_lin = trk * {20'h00000, geom_spt} + {20'h00000, sect - 8'h01};
  endfunction : chs_lin

  assign addr_bad = lba_mode ? (cur_lba > max_lba)
                             : (!geom_valid || sect == 8'h00 ||
                                sect > geom_spt || dev_hd[3:0] > geom_heads ||
                                chs_lin() > max_lba);

  // ----------------------------------------------------------
  // Info record, two bytes per data word
  // ----------------------------------------------------------
  function automatic logic [7:0] rec_byte(input logic [7:0] b);
    logic [7:0] v;
    v = 8'h00;
    unique case (b)
      8'h00: v = lba_mode ? 8'h00 : cyl_hi;
      8'h01: v = lba_mode ? 8'h00 : cyl_lo;
      8'h02: v = lba_mode ? 8'h00 : {4'h0, dev_hd[3:0]};
      8'h03: v = lba_mode ? 8'h00 : sect;
      8'h04: v = lba_mode ? cyl_hi : 8'h00;
      8'h05: v = lba_mode ? cyl_lo : 8'h00;
      8'h06: v = lba_mode ? sect : 8'h00;
      `FSW_REC_ERASED: v = sect_info.erased ? `FSW_BYTE_ONES : 8'h00;
      `FSW_REC_WC_HI: v = sect_info.wcount[23:16];
      `FSW_REC_WC_MD: v = sect_info.wcount[15:8];
      `FSW_REC_WC_LO: v = sect_info.wcount[7:0];
      default: v = 8'h00;
    endcase
    rec_byte = v;
  endfunction : rec_byte

  // Second half of the record is reserved and reads as zero
  logic [15:0] info_word;
  assign info_word = word_idx[7] ? 16'h0000 : {rec_byte({word_idx[6:0], 1'b1}),
                      rec_byte({word_idx[6:0], 1'b0})};

  // ----------------------------------------------------------
  // Command issue and sequencing
  // ----------------------------------------------------------
  logic cmd_wr;
  logic data_rd;
  logic data_wr;
  logic sect_end;
  logic blk_end;
  logic last_sect;
  logic [7:0] opc;

  assign opc       = wb_dat_i[7:0];
  assign cmd_wr    = wr_acc && lane0 && hit(`FSW_OFS_STAT) && !busy_flag && !data_request_flag;
  assign data_rd   = rd_acc && hit(`FSW_OFS_DATA) && state == FSW_INFO;
  assign data_wr   = wr_acc && lane0 && lane1 && hit(`FSW_OFS_DATA)
                     && state == FSW_WRITE;
  assign sect_end  = (data_rd || data_wr) && word_idx == `FSW_WORDS_SECT;
  assign last_sect = left == 9'h001;
  assign blk_end   = sect_end && (blk_left == 8'h01 || last_sect);
  assign busy_cmd  = 1'b0;

  // Write failure seen at the last word of a sector
  logic wr_fail;
  assign wr_fail = data_wr && sect_end && (media_err || dev_fault);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= FSW_IDLE;
    end else begin
      unique case (state)
        FSW_IDLE: begin
          if (cmd_wr && opc == `FSW_OP_INFO && !addr_bad) begin
            state <= FSW_INFO;
          end else if (cmd_wr && opc == `FSW_OP_WRMULT && !addr_bad
                       && mult != 8'h00) begin
            state <= FSW_WRITE;
          end
        end
        FSW_INFO: begin
          if (sect_end) begin
            state <= FSW_IDLE;
          end
        end
        FSW_WRITE: begin
          if (wr_fail || (sect_end && last_sect)) begin
            state <= FSW_IDLE;
          end
        end
      endcase
    end
  end

  // Word index within the current sector
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      word_idx <= 8'h00;
    end else if (cmd_wr || sect_end) begin
      word_idx <= 8'h00;
    end else if (data_rd || data_wr) begin
      word_idx <= word_idx + 8'h01;
    end
  end

  // Sectors left and sectors left in the current block
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      left     <= 9'h000;
      blk_left <= 8'h00;
    end else if (cmd_wr) begin
      left     <= (count == 8'h00) ? 9'h100 : {1'b0, count};
      blk_left <= mult;
    end else if (data_wr && sect_end) begin
      left     <= left - 9'h001;
      blk_left <= blk_end ? mult : blk_left - 8'h01;
    end
  end

  // Status: data request and fault
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_request_flag <= 1'b0;
      busy_flag <= 1'b0;
      df  <= 1'b0;
    end else begin
      busy_flag <= busy_cmd;
      if (cmd_wr) begin
        data_request_flag <= (opc == `FSW_OP_INFO || (opc == `FSW_OP_WRMULT && mult != 8'h00))
               && !addr_bad;
        df  <= 1'b0;
      end else if (wr_fail) begin
        data_request_flag <= 1'b0;
        df  <= dev_fault;
      end else if (sect_end && (state == FSW_INFO || last_sect)) begin
        data_request_flag <= 1'b0;
      end
    end
  end

  // Error register; cleared at each new command
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      err_reg <= 8'h00;
    end else if (cmd_wr) begin
      err_reg <= 8'h00;
      if (opc != `FSW_OP_INFO && opc != `FSW_OP_WRMULT) begin
        err_reg[`FSW_ER_ABORTED_COMMAND_BIT] <= 1'b1;
      end else if (addr_bad) begin
        err_reg[`FSW_ER_ADDRESS_NOT_FOUND_BIT] <= 1'b1;
      end else if (opc == `FSW_OP_WRMULT && mult == 8'h00) begin
        err_reg[`FSW_ER_ABORTED_COMMAND_BIT] <= 1'b1;
      end
    end else if (wr_fail) begin
      err_reg[`FSW_ER_MED]  <= media_err;
      err_reg[`FSW_ER_ABORTED_COMMAND_BIT] <= !media_err;
    end
  end

  // Interrupt at command issue, first info word and each write block end; cleared by a status read
  logic stat_rd;
  assign stat_rd = rd_acc && hit(`FSW_OFS_STAT);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      host_irq <= 1'b0;
    end else if (blk_end && state == FSW_WRITE) begin
      host_irq <= 1'b1;
    end else if (cmd_wr || (data_rd && word_idx == 8'h00)) begin
      host_irq <= 1'b1;
    end else if (stat_rd) begin
      host_irq <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Task-file registers
  // ----------------------------------------------------------
  // Address registers advance per sector so a failure leaves the
  // failing sector in them.
  logic [7:0] next_sect;
  logic [7:0] next_cyl_lo;
  logic [7:0] next_cyl_hi;
  logic [3:0] next_head;
  logic       track_wrap;
  logic       head_wrap;

  assign track_wrap = sect >= geom_spt;
  assign head_wrap  = dev_hd[3:0] >= geom_heads;

  always_comb begin
    if (lba_mode) begin
      {next_head, next_cyl_hi, next_cyl_lo, next_sect} = next_lba;
    end else begin
      next_sect   = track_wrap ? 8'h01 : sect + 8'h01;
      next_head   = !track_wrap ? dev_hd[3:0] : head_wrap ? 4'h0
                    : dev_hd[3:0] + 4'h1;
      {next_cyl_hi, next_cyl_lo} = (track_wrap && head_wrap)
                    ? {cyl_hi, cyl_lo} + 16'h0001 : {cyl_hi, cyl_lo};
    end
  end

  logic tf_wr;
  assign tf_wr = wr_acc && lane0 && !busy_flag && !data_request_flag;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count  <= 8'h01;
      sect   <= 8'h01;
      cyl_lo <= 8'h00;
      cyl_hi <= 8'h00;
      dev_hd <= 8'h00;
      mult   <= 8'h00;
    end else if (data_wr && sect_end && !wr_fail && !last_sect) begin
      sect   <= next_sect;
      cyl_lo <= next_cyl_lo;
      cyl_hi <= next_cyl_hi;
      dev_hd <= {dev_hd[7:4], next_head};
    end else if (tf_wr) begin
      if (hit(`FSW_OFS_COUNT)) count  <= wb_dat_i[7:0];
      if (hit(`FSW_OFS_SECT))  sect   <= wb_dat_i[7:0];
      if (hit(`FSW_OFS_CYLLO)) cyl_lo <= wb_dat_i[7:0];
      if (hit(`FSW_OFS_CYLHI)) cyl_hi <= wb_dat_i[7:0];
      if (hit(`FSW_OFS_DEVHD)) dev_hd <= wb_dat_i[7:0];
      if (hit(`FSW_OFS_MULT))  mult   <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------------------------
  // Flash write port: words go straight out, no erase step
  // ----------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      media_wr_vld <= 1'b0;
      media_wr     <= '0;
    end else begin
      media_wr_vld <= data_wr;
      if (data_wr) begin
        media_wr <= '{addr: cur_lba, word_idx: word_idx,
                      data: wb_dat_i[15:0]};
      end
    end
  end

  // ----------------------------------------------------------
  // Read data
  // ----------------------------------------------------------
  logic [7:0] status;
  assign status = {busy_flag, !busy_flag, df, 1'b0, data_request_flag, 2'b00,
                   |err_reg};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h00000000;
    end else if (rd_acc) begin
      unique case (wb_adr_i)
        `FSW_OFS_DATA:  wb_dat_o <= {16'h0000, data_rd ? info_word : 16'h0000};
        `FSW_OFS_ERR:   wb_dat_o <= {24'h000000, err_reg};
        `FSW_OFS_COUNT: wb_dat_o <= {24'h000000, count};
        `FSW_OFS_SECT:  wb_dat_o <= {24'h000000, sect};
        `FSW_OFS_CYLLO: wb_dat_o <= {24'h000000, cyl_lo};
        `FSW_OFS_CYLHI: wb_dat_o <= {24'h000000, cyl_hi};
        `FSW_OFS_DEVHD: wb_dat_o <= {24'h000000, dev_hd};
        `FSW_OFS_STAT:  wb_dat_o <= {24'h000000, status};
        `FSW_OFS_MULT:  wb_dat_o <= {24'h000000, mult};
        default:        wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  sequence s_info_cmd;
    cmd_wr && opc == `FSW_OP_INFO && !addr_bad;
  endsequence

  a_info_starts: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_info_cmd |=> state == FSW_INFO && data_request_flag)
    else $error("info command did not start");

  a_info_ends: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state == FSW_INFO && sect_end) |=> state == FSW_IDLE && !data_request_flag)
    else $error("info transfer length wrong");

  a_erased_byte: assert property (@(posedge core_clk) disable iff (!rst_b)
    (data_rd && word_idx == 8'h09) |=>
      wb_dat_o[15:8] == ($past(sect_info.erased) ? 8'hFF : 8'h00))
    else $error("erased flag byte wrong");

  a_abort_unknown: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cmd_wr && opc != `FSW_OP_INFO && opc != `FSW_OP_WRMULT) |=>
      err_reg[`FSW_ER_ABORTED_COMMAND_BIT] && state == FSW_IDLE)
    else $error("unknown opcode not aborted");

  a_err_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    stat_rd |=> wb_dat_o[`FSW_ST_ERR] == $past(err_reg != 8'h00))
    else $error("error flag mismatch");

  a_count_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cmd_wr && count == 8'h00) |=> left == 9'h100)
    else $error("zero count not 256");

  a_fail_drops: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_fail |=> !data_request_flag && state == FSW_IDLE && err_reg != 8'h00)
    else $error("failed write left request up");

  a_one_of_two: assert property (@(posedge core_clk) disable iff (!rst_b)
    !(err_reg[`FSW_ER_ADDRESS_NOT_FOUND_BIT] && err_reg[`FSW_ER_ABORTED_COMMAND_BIT]))
    else $error("both not-found and abort set");

  a_block_irq: assert property (@(posedge core_clk) disable iff (!rst_b)
    (data_wr && sect_end && !blk_end) |=> !$rose(host_irq))
    else $error("interrupt inside block");

  a_ready_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state != FSW_IDLE) ##1 (state == FSW_IDLE) |-> status[`FSW_ST_DRIVE_READY_FLAG]
      && !status[`FSW_ST_BSY])
    else $error("not ready after command");

endmodule : fsw_cmd
`default_nettype wire

// [sim/fsw_flash_model.sv]
// Flash array stand-in: takes write words, checks address and order,
// and injects a media error or a fault from a chosen sector on.
// Assumes the bench pulses clr before each write command.
`timescale 1ns/1ps
`default_nettype none
module fsw_flash_model
  import fsw_pkg::*;
(
  input  wire logic          core_clk,     // clock
  input  wire logic          rst_b,        // async reset
  input  wire logic          clr,          // new command
  input  wire fsw_media_wr_t media_wr,     // write word
  input  wire logic          media_wr_vld, // write strobe
  input  wire logic [27:0]   exp_base,     // first sector
  input  wire logic          fail_en,      // inject failure
  input  wire logic          fail_kind,    // 1 fault, 0 media
  input  wire logic [7:0]    fail_sect,    // failing index
  output logic               media_err,    // to block
  output logic               dev_fault,    // to block
  output logic [15:0]        n_words,      // words taken
  output logic [15:0]        n_bad         // wrong words
);
  logic [7:0] sect_idx;
  logic       hit;

  assign sect_idx  = n_words[15:8];
  // Held from the failing sector on, so the sampling instant cannot miss it
  assign hit       = fail_en && (sect_idx >= fail_sect);
  assign media_err = hit && !fail_kind;
  assign dev_fault = hit && fail_kind;

  // Words land where addressed; nothing is erased first
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      n_words <= 16'h0000;
      n_bad   <= 16'h0000;
    end else if (clr) begin
      n_words <= 16'h0000;
      n_bad   <= 16'h0000;
    end else if (media_wr_vld) begin
      n_words <= n_words + 16'h0001;
      if (media_wr.addr !== exp_base + {20'h00000, sect_idx} ||
          media_wr.word_idx !== n_words[7:0] ||
          media_wr.data !== {sect_idx, n_words[7:0]}) begin
        n_bad <= n_bad + 16'h0001;
      end
    end
  end
endmodule : fsw_flash_model
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench: plays the host over classic Wishbone.
// Assumes the flash model on the media side of the block.
`timescale 1ns/1ps
`default_nettype none
module tb
  import fsw_pkg::*;
;
  logic           core_clk   = 1'h0;
  logic           rst_b      = 1'h0;
  logic           wb_cyc     = 1'h0;
  logic           wb_stb     = 1'h0;
  logic           wb_we      = 1'h0;
  logic [5:0]     wb_adr     = 6'h00;
  logic [3:0]     wb_sel     = 4'hF;
  logic [31:0]    wb_dat     = 32'h00000000;
  logic [31:0]    wb_dat_o;
  logic           wb_ack_o;
  fsw_sect_info_t sect_info  = '0;
  logic           geom_valid = 1'h1;
  logic           media_err;
  logic           dev_fault;
  fsw_media_wr_t  media_wr;
  logic           media_wr_vld;
  logic           host_irq;
  logic           clr        = 1'h0;
  logic [27:0]    exp_base   = 28'h0000000;
  logic           fail_en    = 1'h0;
  logic           fail_kind  = 1'h0;
  logic [7:0]     fail_sect  = 8'h00;
  logic [15:0]    n_words;
  logic [15:0]    n_bad;
  logic [31:0]    seed       = 32'h46221093;
  int             err_total  = 0;
  int             n_checks   = 0;

  always #2 core_clk = ~core_clk;

  fsw_cmd u_dut (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sect_info(sect_info), .geom_valid(geom_valid), .geom_spt(8'h3F),
    .geom_heads(4'hF), .max_lba(28'h0FFFFFF), .media_err(media_err),
    .dev_fault(dev_fault), .media_wr(media_wr), .media_wr_vld(media_wr_vld),
    .host_irq(host_irq));

  fsw_flash_model u_flash (.core_clk(core_clk), .rst_b(rst_b), .clr(clr),
    .media_wr(media_wr), .media_wr_vld(media_wr_vld), .exp_base(exp_base),
    .fail_en(fail_en), .fail_kind(fail_kind), .fail_sect(fail_sect),
    .media_err(media_err), .dev_fault(dev_fault), .n_words(n_words),
    .n_bad(n_bad));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Returns {check, byte}; bytes outside the defined fields are skipped
  function automatic logic [8:0] rec_byte(input logic [7:0] i, input logic [7:0] s,
      input logic [7:0] cl, input logic [7:0] ch, input logic [7:0] dh,
      input fsw_sect_info_t si);
    logic l;
    l = dh[6];
    case (i)
      8'h00: return {1'h1, l ? 8'h00 : ch};
      8'h01: return {1'h1, l ? 8'h00 : cl};
      8'h02: return {1'h1, l ? 8'h00 : {4'h0, dh[3:0]}};
      8'h03: return {1'h1, l ? 8'h00 : s};
      8'h04: return {1'h1, l ? ch : 8'h00};
      8'h05: return {1'h1, l ? cl : 8'h00};
      8'h06: return {1'h1, l ? s : 8'h00};
      8'h13: return {1'h1, si.erased ? 8'hFF : 8'h00};
      8'h18: return {1'h1, si.wcount[23:16]};
      8'h19: return {1'h1, si.wcount[15:8]};
      8'h1A: return {1'h1, si.wcount[7:0]};
      default: return 9'h000;
    endcase
  endfunction : rec_byte

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  // One classic cycle; ack and read data are taken at the same edge
  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d,
      output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 40);
    rd = wb_dat_o;
    if (n >= 40) chk(32'h0, 32'h1, "ack timeout");
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
  endtask : bus

  task automatic wr8(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] t;
    bus(1'h1, a, {24'h000000, d}, t);
  endtask : wr8

  task automatic rchk(input logic [5:0] a, input logic [7:0] e, input string m);
    logic [31:0] t;
    bus(1'h0, a, 32'h00000000, t);
    chk({24'h000000, t[7:0]}, {24'h000000, e}, m);
  endtask : rchk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic info_run(input logic lba);
    logic [31:0] r;
    logic [31:0] t;
    logic [7:0]  s, cl, ch, dh;
    logic [8:0]  lo, hi;
    r  = rnd();
    s  = lba ? r[7:0] : 8'(1 + r[7:0] % 63);
    cl = r[15:8];
    ch = lba ? {1'h0, r[22:16]} : 8'h00;
    dh = lba ? 8'h40 : {4'h0, r[27:24]};
    t = rnd();
    sect_info <= {r[31], t[23:0]};
    wr8(6'h0C, s);
    wr8(6'h10, cl);
    wr8(6'h14, ch);
    wr8(6'h18, dh);
    bus(1'h0, 6'h1C, 32'h00000000, t);
    chk({31'h0, t[6]}, 32'h1, "ready before issue");
    wr8(6'h1C, 8'h87);
    repeat (2) @(posedge core_clk);
    chk({31'h0, host_irq}, 32'h1, "irq at issue");
    rchk(6'h1C, 8'h48, "status data ready");
    for (int w = 0; w < 256; w++) begin
      if (w == 255) rchk(6'h1C, 8'h48, "status before last word");
      bus(1'h0, 6'h00, 32'h00000000, t);
      lo = (w < 128) ? rec_byte(8'(2 * w), s, cl, ch, dh, sect_info) : 9'h100;
      hi = (w < 128) ? rec_byte(8'(2 * w + 1), s, cl, ch, dh, sect_info) : 9'h100;
      if (lo[8]) chk({24'h0, t[7:0]}, {24'h0, lo[7:0]}, "record low byte");
      if (hi[8]) chk({24'h0, t[15:8]}, {24'h0, hi[7:0]}, "record high byte");
    end
    rchk(6'h1C, 8'h40, "status after record");
    rchk(6'h04, 8'h00, "error after record");
    bus(1'h0, 6'h00, 32'h00000000, t);
    chk(t, 32'h00000000, "read past record");
    $display("test info lba=%0d done", lba);
  endtask : info_run

  task automatic err_run(input logic [7:0] op, input logic [7:0] e, input string m);
    wr8(6'h1C, op);
    rchk(6'h04, e, m);
    rchk(6'h1C, 8'h41, "status on error end");
  endtask : err_run

  task automatic write_run(input int cnt, input logic [7:0] mult, input logic fe,
      input logic fk, input int fs);
    logic [27:0] b;
    logic [27:0] f;
    logic [31:0] t;
    b = 28'(rnd() & 32'h007FFF00);
    f = b + 28'(fs);
    wr8(6'h20, mult);
    wr8(6'h08, 8'(cnt));
    wr8(6'h0C, b[7:0]);
    wr8(6'h10, b[15:8]);
    wr8(6'h14, b[23:16]);
    wr8(6'h18, 8'h40);
    exp_base  <= b;
    fail_en   <= fe;
    fail_kind <= fk;
    fail_sect <= 8'(fs);
    clr       <= 1'h1;
    @(posedge core_clk);
    clr <= 1'h0;
    wr8(6'h1C, 8'hCD);
    rchk(6'h1C, 8'h48, "status write ready");
    for (int s = 0; s < cnt; s++) begin
      for (int w = 0; w < 256; w++) begin
        bus(1'h1, 6'h00, {16'h0000, 8'(s), 8'(w)}, t);
      end
      repeat (3) @(posedge core_clk);
      if (fe && s == fs) break;
      chk({31'h0, host_irq}, {31'h0, ((s + 1) % mult == 0) || (s == cnt - 1)},
          "block interrupt");
      rchk(6'h1C, (s == cnt - 1) ? 8'h40 : 8'h48, "status per sector");
    end
    if (fe) begin
      rchk(6'h1C, fk ? 8'h61 : 8'h41, "status after failure");
      rchk(6'h04, fk ? 8'h04 : 8'h01, "error after failure");
      rchk(6'h0C, f[7:0], "failing sector low");
      rchk(6'h10, f[15:8], "failing sector mid");
      rchk(6'h14, f[23:16], "failing sector high");
      fail_en <= 1'h0;
    end else begin
      chk({16'h0, n_words}, 32'(cnt * 256), "words written");
    end
    chk({16'h0, n_bad}, 32'h0, "media word order");
    $display("test write cnt=%0d fail=%0d done", cnt, fe);
  endtask : write_run

  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'h1;
    rchk(6'h1C, 8'h40, "status at reset");
    rchk(6'h08, 8'h01, "count at reset");
    rchk(6'h0C, 8'h01, "sector at reset");
    rchk(6'h30, 8'h00, "unmapped read");
    for (int i = 0; i < 4; i++) info_run(i[0]);
    err_run(8'h20, 8'h04, "unknown opcode");
    err_run(8'hFF, 8'h04, "unknown opcode");
    err_run(8'h38, 8'h04, "unknown opcode");
    wr8(6'h20, 8'h00);
    err_run(8'hCD, 8'h04, "write without block size");
    wr8(6'h18, 8'h41);
    err_run(8'h87, 8'h10, "lba out of range");
    geom_valid <= 1'h0;
    wr8(6'h18, 8'h02);
    err_run(8'h87, 8'h10, "no geometry");
    geom_valid <= 1'h1;
    write_run(3, 8'h02, 1'h0, 1'h0, 0);
    write_run(1 + rnd() % 4, 8'(1 + rnd() % 3), 1'h0, 1'h0, 0);
    write_run(2, 8'h01, 1'h1, 1'h0, 1);
    write_run(256, 8'h02, 1'h1, 1'h1, 0);
    info_run(1'h1);
    give_verdict();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
